// >>> src/scbr_cfg.svh
// Offsets, field positions, reset values and timing counts of the system control register bank.
`ifndef SCBR_CFG_SVH
`define SCBR_CFG_SVH
`define SCBR_OFS_CPU_CLK 8'h00
`define SCBR_OFS_CE_SEL 8'h02
`define SCBR_OFS_BOOT_EVT 8'h04
`define SCBR_OFS_RAM_PAGE 8'h05
`define SCBR_OFS_SRC_LOW 8'h06
`define SCBR_OFS_SRC_MID 8'h07
`define SCBR_OFS_SRC_HIGH 8'h09
`define SCBR_OFS_SRC_PAGE 8'h0A
`define SCBR_OFS_DST_LOW 8'h0B
`define SCBR_OFS_DST_MID 8'h0C
`define SCBR_OFS_DST_HIGH 8'h0E
`define SCBR_OFS_DST_PAGE 8'h0F
`define SCBR_OFS_CNT_LOW 8'h10
`define SCBR_OFS_CNT_HIGH 8'h11
`define SCBR_OFS_DMA_MODE 8'h12
`define SCBR_OFS_DMA_DIV 8'h29
`define SCBR_OFS_SCRATCH 8'h3F
`define SCBR_OFS_SYS_SET 8'hA6
`define SCBR_MASK_CPU_CLK 8'hF7
`define SCBR_MASK_CE_SEL 8'hFF
`define SCBR_MASK_RAM_PAGE 8'hF7
`define SCBR_MASK_ADDR_HIGH 8'hC7
`define SCBR_MASK_PAGE 8'h07
`define SCBR_MASK_CNT_HIGH 8'h7F
`define SCBR_MASK_DMA_MODE 8'hDB
`define SCBR_MASK_DMA_DIV 8'h07
`define SCBR_RST_CE_SEL 8'h08
`define SCBR_RST_DMA_PAGE 3'h3
`define SCBR_BIT_WDOG 7
`define SCBR_BIT_EXTRST 6
`define SCBR_BIT_LBAT 5
`define SCBR_BIT_EDGE 3
`define SCBR_BIT_IRQ_EN 2
`define SCBR_BIT_LBAT_EN 1
`define SCBR_BIT_BOOT 0
`define SCBR_BIT_SHORT 7
`define SCBR_BIT_LONG 6
`define SCBR_DIV_STOP 3'h7
`define SCBR_PAGE_ORIG 2'h0
`define SCBR_PRESS_MS 10
`define SCBR_CLK_MHZ 100
`define SCBR_PRESS_CYCLES (`SCBR_PRESS_MS * `SCBR_CLK_MHZ * 1000)
`endif

// >>> src/scbr_pkg.sv
// Types shared by the system control register bank modules.
package scbr_pkg;
    typedef enum logic [1:0] {SRC_LOW_OSC, SRC_HIGH_OSC, SRC_PLL, SRC_RESERVED} scbr_clk_src_t;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } scbr_io_req_t;
    typedef struct packed {
        logic ext_mem;
        logic banked;
        logic [2:0] page;
        logic [2:0] upper;
        logic [15:0] low;
    } scbr_dma_addr_t;
    typedef struct packed {
        logic [1:0] wait_states;
        logic dst_down;
        logic src_down;
        logic dst_io;
        logic src_io;
    } scbr_dma_mode_t;
    typedef struct packed {
        logic [3:0] owner_mcu;
        logic [2:0] ext_page;
    } scbr_ram_map_t;
endpackage : scbr_pkg

// >>> src/scbr_clkdiv.sv
// Power-of-two clock enable divider with an optional stop code.
`include "scbr_cfg.svh"
module scbr_clkdiv #(
    parameter int unsigned CNT_W = 7,
    parameter bit STOP_ON_MAX = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] code,
    output logic tick
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    // Terminal count is two to the power of the code, minus one.
    always_comb begin
        limit = CNT_W'((1 << code) - 1);
    end

    // Free counter; the code 111 halts the enable when stopping is allowed.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= '0;
            tick <= 1'b0;
        end else if (STOP_ON_MAX && code == `SCBR_DIV_STOP) begin
            count <= '0;
            tick <= 1'b0;
        end else if (count >= limit) begin
            count <= '0;
            tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : scbr_clkdiv

// >>> src/scbr_keypress.sv
// Short and long press detection for the power key.
`include "scbr_cfg.svh"
module scbr_keypress #(
    parameter int unsigned PRESS_CYCLES = `SCBR_PRESS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic key_down,
    input wire logic clear_short,
    output logic short_flag,
    output logic long_flag
);
    typedef enum logic [1:0] {KEY_IDLE, KEY_TIMING, KEY_LONG, KEY_WAIT} scbr_key_state_t;
    scbr_key_state_t state;
    logic [31:0] count;
    logic armed;

    // Press timer; a long press holds off recounting until release.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= KEY_IDLE;
            count <= '0;
            long_flag <= 1'b0;
        end else begin
            unique case (state)
                KEY_IDLE: begin
                    count <= '0;
                    long_flag <= 1'b0;
                    if (key_down && armed) begin
                        state <= KEY_TIMING;
                    end
                end
                KEY_TIMING: begin
                    count <= count + 1'b1;
                    if (!key_down) begin
                        state <= KEY_IDLE;
                    end else if (count >= PRESS_CYCLES) begin
                        state <= KEY_LONG;
                        long_flag <= 1'b1;
                    end
                end
                KEY_LONG: begin
                    if (!key_down) begin
                        state <= KEY_IDLE;
                    end
                end
                KEY_WAIT: begin
                    state <= KEY_IDLE;
                end
            endcase
        end
    end

    // Short flag: set on release in time, set wins over clear; rearm on clear while held.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            short_flag <= 1'b0;
            armed <= 1'b1;
        end else if (state == KEY_TIMING && !key_down && armed) begin
            short_flag <= 1'b1;
            armed <= 1'b0;
        end else if (clear_short) begin
            short_flag <= 1'b0;
            if (key_down) begin
                armed <= 1'b1;
            end
        end
    end
endmodule : scbr_keypress

// >>> src/scbr_regs.sv
// System control register bank: RAM assignment, clocks, chip enables, boot and event flags.
`include "scbr_cfg.svh"
// Functional notes
// - Four bits give each shared RAM block to processor (0) or MCU and DMA (1).
// - Three-bit extended page selects which banked RAM the window reaches.
// - Two-bit field adds zero to three external wait states; boot ROM never waits.
// - Two-bit field picks low oscillator, high oscillator, PLL or reserved clock source.
// - Processor clock divides by one to sixty-four; code 111 stops it.
// - Wake events restore a stopped processor clock to the undivided low oscillator.
// - Shared DMA divider divides by one to 128; resets to code 000.
// - Five bits route pins to port or chip enable; chip enable one resets set.
// - Enabled external interrupt blocks chip enable five and its port function.
// - Three-bit selection decodes to chip enables zero to seven.
// - Watchdog flag is set by watchdog events and cleared by writing one.
// - External reset flag is set after external reset; writing one clears.
// - Low battery pending is set when enabled with battery ADC on; write one clears.
// - Interrupt pin enable and edge select; pull-up on falling, pull-down on rising.
// - Boot bit zero forces address line 15 high until software writes one.
// - Scratch byte is readable and writable and resets to zero.
// - Short press flag set on timely release; write one clears; rearms while held.
// - Read-only long press flag; no recount until the key is released.
// - Two-bit page switch selects which register page is reached; resets to 00.
// - DMA addresses add bits 21:19, external select and banked select bits.
// - DMA page fields use the extended page code and reset to 011.
// - DMA byte count is fifteen bits over low and high registers.
// - DMA mode holds wait states, down-count bits and destination IO select.
// - DMA mode bit zero makes the source an IO port; resets to zero.
module scbr_regs #(
    parameter int unsigned PRESS_CYCLES = `SCBR_PRESS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire scbr_pkg::scbr_io_req_t io_req,
    output logic [7:0] io_rdata,
    input wire logic ext_access,
    input wire logic boot_rom_access,
    input wire logic cpu_a15_in,
    input wire logic ext_irq_in,
    input wire logic watchdog_event,
    input wire logic ext_reset_seen,
    input wire logic low_battery_nmi,
    input wire logic battery_adc_en,
    input wire logic button_reset,
    input wire logic alarm_irq,
    input wire logic usb_wake_irq,
    input wire logic lradc_one_irq,
    input wire logic power_key,
    output scbr_pkg::scbr_ram_map_t ram_map,
    output logic [1:0] mem_wait_states,
    output scbr_pkg::scbr_clk_src_t cpu_clk_src,
    output logic cpu_clk_tick,
    output logic dma_clk_tick,
    output logic [4:0] pin_is_chip_enable,
    output logic ext_irq_pin_mode,
    output logic [7:0] chip_enable_n,
    output logic ext_irq_event,
    output logic pull_up_en,
    output logic pull_down_en,
    output logic cpu_a15_out,
    output logic [1:0] reg_page,
    output scbr_pkg::scbr_dma_addr_t dma_one_source_address,
    output scbr_pkg::scbr_dma_addr_t dma_one_dest_address,
    output logic [14:0] dma_one_byte_count,
    output scbr_pkg::scbr_dma_mode_t dma_one_mode
);
    logic [7:0] cpu_clk_reg;
    logic [7:0] ce_sel_reg;
    logic [7:0] ram_page_reg;
    logic [7:0] src_low;
    logic [7:0] src_mid;
    logic [7:0] src_high;
    logic [2:0] src_page;
    logic [7:0] dst_low;
    logic [7:0] dst_mid;
    logic [7:0] dst_high;
    logic [2:0] dst_page;
    logic [7:0] cnt_low;
    logic [6:0] cnt_high;
    logic [7:0] dma_mode_reg;
    logic [2:0] dma_div;
    logic [7:0] scratch;
    logic [1:0] page_sel;
    logic wdog_flag;
    logic extrst_flag;
    logic lbat_flag;
    logic edge_rising;
    logic irq_en;
    logic lbat_en;
    logic boot_done;
    logic irq_prev;
    logic irq_edge;
    logic wake;
    logic short_flag;
    logic long_flag;
    logic cpu_tick_raw;
    logic dma_tick_raw;
    logic [7:0] next_rdata;

    // Register hit on the original page; system settings are reached from every page.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs,
                                 input logic [1:0] page);
        hit = (addr == ofs) && (page == `SCBR_PAGE_ORIG || ofs == `SCBR_OFS_SYS_SET);
    endfunction : hit

    // Write strobe for one register offset.
    function automatic logic wr_hit(input scbr_pkg::scbr_io_req_t req, input logic [7:0] ofs,
                                    input logic [1:0] page);
        wr_hit = req.wr && hit(req.addr, ofs, page);
    endfunction : wr_hit

    // Interrupt pin edge detection in the selected direction while enabled.
    always_comb begin
        irq_edge = irq_en && (edge_rising ? (ext_irq_in && !irq_prev)
                                          : (!ext_irq_in && irq_prev));
        wake = (cpu_clk_reg[2:0] == `SCBR_DIV_STOP) && (button_reset || alarm_irq
               || irq_edge || usb_wake_irq || lradc_one_irq);
    end

    // Previous pin level and registered interrupt event pulse.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_prev <= 1'b0;
            ext_irq_event <= 1'b0;
        end else begin
            irq_prev <= ext_irq_in;
            ext_irq_event <= irq_edge;
        end
    end

    // Processor clock control; a wake event overrides a write in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_clk_reg <= 8'h00;
        end else if (wake) begin
            cpu_clk_reg <= {cpu_clk_reg[7:6], 6'h00};
        end else if (wr_hit(io_req, `SCBR_OFS_CPU_CLK, page_sel)) begin
            cpu_clk_reg <= io_req.wdata & `SCBR_MASK_CPU_CLK;
        end
    end

    // Chip enable selection and pin multiplexing.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ce_sel_reg <= `SCBR_RST_CE_SEL;
        end else if (wr_hit(io_req, `SCBR_OFS_CE_SEL, page_sel)) begin
            ce_sel_reg <= io_req.wdata & `SCBR_MASK_CE_SEL;
        end
    end

    // Boot and event control bits other than the sticky flags.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            edge_rising <= 1'b0;
            irq_en <= 1'b0;
            lbat_en <= 1'b0;
            boot_done <= 1'b0;
        end else if (wr_hit(io_req, `SCBR_OFS_BOOT_EVT, page_sel)) begin
            edge_rising <= io_req.wdata[`SCBR_BIT_EDGE];
            irq_en <= io_req.wdata[`SCBR_BIT_IRQ_EN];
            lbat_en <= io_req.wdata[`SCBR_BIT_LBAT_EN];
            boot_done <= io_req.wdata[`SCBR_BIT_BOOT];
        end
    end

    // Sticky event flags; a new event wins over a write-one clear.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdog_flag <= 1'b0;
            extrst_flag <= 1'b0;
            lbat_flag <= 1'b0;
        end else begin
            if (watchdog_event) begin
                wdog_flag <= 1'b1;
            end else if (wr_hit(io_req, `SCBR_OFS_BOOT_EVT, page_sel)
                         && io_req.wdata[`SCBR_BIT_WDOG]) begin
                wdog_flag <= 1'b0;
            end
            if (ext_reset_seen) begin
                extrst_flag <= 1'b1;
            end else if (wr_hit(io_req, `SCBR_OFS_BOOT_EVT, page_sel)
                         && io_req.wdata[`SCBR_BIT_EXTRST]) begin
                extrst_flag <= 1'b0;
            end
            if (low_battery_nmi && lbat_en && battery_adc_en) begin
                lbat_flag <= 1'b1;
            end else if (wr_hit(io_req, `SCBR_OFS_BOOT_EVT, page_sel)
                         && io_req.wdata[`SCBR_BIT_LBAT]) begin
                lbat_flag <= 1'b0;
            end
        end
    end

    // RAM ownership, extended page, scratch, DMA divider and page switch.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ram_page_reg <= 8'h00;
            scratch <= 8'h00;
            dma_div <= 3'h0;
            page_sel <= `SCBR_PAGE_ORIG;
        end else begin
            if (wr_hit(io_req, `SCBR_OFS_RAM_PAGE, page_sel)) begin
                ram_page_reg <= io_req.wdata & `SCBR_MASK_RAM_PAGE;
            end
            if (wr_hit(io_req, `SCBR_OFS_SCRATCH, page_sel)) begin
                scratch <= io_req.wdata;
            end
            if (wr_hit(io_req, `SCBR_OFS_DMA_DIV, page_sel)) begin
                dma_div <= io_req.wdata[2:0];
            end
            if (wr_hit(io_req, `SCBR_OFS_SYS_SET, page_sel)) begin
                page_sel <= io_req.wdata[1:0];
            end
        end
    end

    // DMA channel one address, page, count and mode registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            src_low <= 8'h00;
            src_mid <= 8'h00;
            src_high <= 8'h00;
            src_page <= `SCBR_RST_DMA_PAGE;
            dst_low <= 8'h00;
            dst_mid <= 8'h00;
            dst_high <= 8'h00;
            dst_page <= `SCBR_RST_DMA_PAGE;
            cnt_low <= 8'h00;
            cnt_high <= 7'h00;
            dma_mode_reg <= 8'h00;
        end else if (io_req.wr && page_sel == `SCBR_PAGE_ORIG) begin
            unique case (io_req.addr)
                `SCBR_OFS_SRC_LOW: src_low <= io_req.wdata;
                `SCBR_OFS_SRC_MID: src_mid <= io_req.wdata;
                `SCBR_OFS_SRC_HIGH: src_high <= io_req.wdata & `SCBR_MASK_ADDR_HIGH;
                `SCBR_OFS_SRC_PAGE: src_page <= io_req.wdata[2:0];
                `SCBR_OFS_DST_LOW: dst_low <= io_req.wdata;
                `SCBR_OFS_DST_MID: dst_mid <= io_req.wdata;
                `SCBR_OFS_DST_HIGH: dst_high <= io_req.wdata & `SCBR_MASK_ADDR_HIGH;
                `SCBR_OFS_DST_PAGE: dst_page <= io_req.wdata[2:0];
                `SCBR_OFS_CNT_LOW: cnt_low <= io_req.wdata;
                `SCBR_OFS_CNT_HIGH: cnt_high <= io_req.wdata[6:0];
                `SCBR_OFS_DMA_MODE: dma_mode_reg <= io_req.wdata & `SCBR_MASK_DMA_MODE;
                default: begin
                end
            endcase
        end
    end

    // Read multiplexer; reserved bits and unmapped offsets return zero.
    always_comb begin
        next_rdata = 8'h00;
        if (page_sel == `SCBR_PAGE_ORIG) begin
            unique case (io_req.addr)
                `SCBR_OFS_CPU_CLK: next_rdata = cpu_clk_reg;
                `SCBR_OFS_CE_SEL: next_rdata = ce_sel_reg;
                `SCBR_OFS_BOOT_EVT: next_rdata = {wdog_flag, extrst_flag, lbat_flag, 1'b0,
                                                  edge_rising, irq_en, lbat_en, boot_done};
                `SCBR_OFS_RAM_PAGE: next_rdata = ram_page_reg;
                `SCBR_OFS_SRC_LOW: next_rdata = src_low;
                `SCBR_OFS_SRC_MID: next_rdata = src_mid;
                `SCBR_OFS_SRC_HIGH: next_rdata = src_high;
                `SCBR_OFS_SRC_PAGE: next_rdata = {5'h00, src_page};
                `SCBR_OFS_DST_LOW: next_rdata = dst_low;
                `SCBR_OFS_DST_MID: next_rdata = dst_mid;
                `SCBR_OFS_DST_HIGH: next_rdata = dst_high;
                `SCBR_OFS_DST_PAGE: next_rdata = {5'h00, dst_page};
                `SCBR_OFS_CNT_LOW: next_rdata = cnt_low;
                `SCBR_OFS_CNT_HIGH: next_rdata = {1'b0, cnt_high};
                `SCBR_OFS_DMA_MODE: next_rdata = dma_mode_reg;
                `SCBR_OFS_DMA_DIV: next_rdata = {5'h00, dma_div};
                `SCBR_OFS_SCRATCH: next_rdata = scratch;
                default: next_rdata = 8'h00;
            endcase
        end
        if (io_req.addr == `SCBR_OFS_SYS_SET) begin
            next_rdata = {short_flag, long_flag, 4'h0, page_sel};
        end
    end

    // Registered read data, valid the cycle after a read strobe.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else if (io_req.rd) begin
            io_rdata <= next_rdata;
        end
    end

    // Registered control outputs for memory, pins and the processor bus.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ram_map <= '0;
            mem_wait_states <= 2'h0;
            cpu_clk_src <= scbr_pkg::SRC_LOW_OSC;
            pin_is_chip_enable <= 5'h01;
            ext_irq_pin_mode <= 1'b0;
            chip_enable_n <= 8'hFF;
            pull_up_en <= 1'b0;
            pull_down_en <= 1'b0;
            cpu_a15_out <= 1'b1;
            reg_page <= `SCBR_PAGE_ORIG;
            cpu_clk_tick <= 1'b0;
            dma_clk_tick <= 1'b0;
        end else begin
            ram_map <= {ram_page_reg[7:4], ram_page_reg[2:0]};
            mem_wait_states <= boot_rom_access ? 2'h0 : cpu_clk_reg[7:6];
            cpu_clk_src <= scbr_pkg::scbr_clk_src_t'(cpu_clk_reg[5:4]);
            pin_is_chip_enable <= {ce_sel_reg[7] && !irq_en, ce_sel_reg[6:3]};
            ext_irq_pin_mode <= irq_en;
            chip_enable_n <= ~(ext_access ? (8'h01 << ce_sel_reg[2:0]) : 8'h00);
            pull_up_en <= irq_en && !edge_rising;
            pull_down_en <= irq_en && edge_rising;
            cpu_a15_out <= boot_done ? cpu_a15_in : 1'b1;
            reg_page <= page_sel;
            cpu_clk_tick <= cpu_tick_raw;
            dma_clk_tick <= dma_tick_raw;
        end
    end

    // DMA channel one configuration outputs.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dma_one_source_address <= '0;
            dma_one_dest_address <= '0;
            dma_one_byte_count <= 15'h0000;
            dma_one_mode <= '0;
        end else begin
            dma_one_source_address <= {src_high[7], src_high[6], src_page, src_high[2:0],
                                       src_mid, src_low};
            dma_one_dest_address <= {dst_high[7], dst_high[6], dst_page, dst_high[2:0],
                                     dst_mid, dst_low};
            dma_one_byte_count <= {cnt_high, cnt_low};
            dma_one_mode <= {dma_mode_reg[7:6], dma_mode_reg[4:3],
                             dma_mode_reg[1:0]};
        end
    end

    // Processor clock divider with stop code.
    scbr_clkdiv #(
        .CNT_W(7),
        .STOP_ON_MAX(1'b1)
    ) u_cpu_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .code(cpu_clk_reg[2:0]),
        .tick(cpu_tick_raw)
    );

    // Shared DMA clock divider.
    scbr_clkdiv #(
        .CNT_W(8),
        .STOP_ON_MAX(1'b0)
    ) u_dma_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .code(dma_div),
        .tick(dma_tick_raw)
    );

    // Power key press detector.
    scbr_keypress #(
        .PRESS_CYCLES(PRESS_CYCLES)
    ) u_key (
        .sys_clk(sys_clk),
        .rst(rst),
        .key_down(power_key),
        .clear_short(wr_hit(io_req, `SCBR_OFS_SYS_SET, page_sel)
                     && io_req.wdata[`SCBR_BIT_SHORT]),
        .short_flag(short_flag),
        .long_flag(long_flag)
    );
endmodule : scbr_regs

// >>> sim/scbr_regs_chk.sv
// Port assertions for the system control register bank.
module scbr_regs_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire scbr_pkg::scbr_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic ext_access,
    input wire logic boot_rom_access,
    input wire logic cpu_a15_in,
    input wire logic [1:0] mem_wait_states,
    input wire logic [4:0] pin_is_chip_enable,
    input wire logic ext_irq_pin_mode,
    input wire logic [7:0] chip_enable_n,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic cpu_a15_out,
    input wire logic [1:0] reg_page
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // A write of one to the boot bit through the original page.
    sequence s_boot_wr;
        io_req.wr && io_req.addr == 8'h04 && io_req.wdata[0] && reg_page == 2'h0;
    endsequence
    a_boot_wait_none: assert property (boot_rom_access |=> mem_wait_states == 2'h0)
        else $error("wait states on boot ROM access");
    a_boot_release: assert property (s_boot_wr ##2 1 |-> cpu_a15_out == $past(cpu_a15_in))
        else $error("address line 15 still forced");
    a_rd_unmapped: assert property (io_req.rd && io_req.addr == 8'h01 |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ce_onehot: assert property ($onehot0(~chip_enable_n))
        else $error("several chip enables low");
    a_ce_idle: assert property (!ext_access |=> chip_enable_n == 8'hFF)
        else $error("chip enable low without access");
    a_irq_blocks_ce: assert property (ext_irq_pin_mode |-> !pin_is_chip_enable[4])
        else $error("chip enable five not blocked");
    a_pull_by_mode: assert property ((pull_up_en || pull_down_en) == ext_irq_pin_mode
        && !(pull_up_en && pull_down_en))
        else $error("pull resistors wrong");
    a_reset_values: assert property ($fell(rst) |-> cpu_a15_out
        && pin_is_chip_enable == 5'h01 && chip_enable_n == 8'hFF)
        else $error("wrong output after reset");
endmodule : scbr_regs_chk
bind scbr_regs scbr_regs_chk i_scbr_regs_chk (.sys_clk, .rst, .io_req, .io_rdata, .ext_access,
    .boot_rom_access, .cpu_a15_in, .mem_wait_states, .pin_is_chip_enable, .ext_irq_pin_mode,
    .chip_enable_n, .pull_up_en, .pull_down_en, .cpu_a15_out, .reg_page);

// >>> sim/scbr_regs_tb_top.sv
// Self-checking bench for the system control register bank.
module scbr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] OFS [18] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0A,
        8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h29, 8'h3F, 8'hA6};
    localparam logic [7:0] MSK [18] = '{8'hF7, 8'hFF, 8'h0F, 8'hF7, 8'hFF, 8'hFF, 8'hC7, 8'h07,
        8'hFF, 8'hFF, 8'hC7, 8'h07, 8'hFF, 8'h7F, 8'hDB, 8'h07, 8'hFF, 8'h03};
    logic sys_clk = 1'b0, rst = 1'b1, ea = 1'b0, bra = 1'b0, a15 = 1'b0, key = 1'b0;
    logic tick, a15o, dtk;
    logic [7:0] ev = '0;
    logic [7:0] rdv, cen;
    logic [1:0] ws;
    logic [7:0] m [256] = '{default: 8'h00};
    logic [7:0] k [256] = '{default: 8'h00};
    logic [14:0] bc;
    scbr_pkg::scbr_ram_map_t rm;
    scbr_pkg::scbr_io_req_t q = '0;
    int n_mismatch = 0, check_count = 0, tk = 0, td = 0;
    scbr_regs #(.PRESS_CYCLES(20)) i_scbr_regs (.sys_clk, .rst, .io_req(q), .io_rdata(rdv),
        .ext_access(ea), .boot_rom_access(bra), .cpu_a15_in(a15), .ext_irq_in(!ev[7]),
        .watchdog_event(ev[0]), .ext_reset_seen(ev[1]), .low_battery_nmi(ev[2]),
        .battery_adc_en(1'b1), .button_reset(ev[3]), .alarm_irq(ev[4]), .usb_wake_irq(ev[5]),
        .lradc_one_irq(ev[6]), .power_key(key), .ram_map(rm), .mem_wait_states(ws),
        .cpu_clk_src(), .cpu_clk_tick(tick), .dma_clk_tick(dtk), .pin_is_chip_enable(),
        .ext_irq_pin_mode(), .chip_enable_n(cen), .ext_irq_event(), .pull_up_en(),
        .pull_down_en(), .cpu_a15_out(a15o), .reg_page(), .dma_one_source_address(),
        .dma_one_dest_address(), .dma_one_byte_count(bc), .dma_one_mode());
    // Clock, random boot ROM accesses and processor and DMA tick counting.
    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) bra <= 1'($urandom);
    always @(posedge sys_clk) tk <= tk + 32'(tick);
    always @(posedge sys_clk) td <= td + 32'(dtk);
    // Compares one value and counts the outcome.
    task automatic chk(string s, logic [14:0] e, logic [14:0] v);
        check_count++;
        if (v !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", s, e, v);
        end
    endtask : chk
    // Register port cycles; the model keeps writes that the page switch lets through.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        q <= '{a, 1'b1, 1'b0, d};
        @(negedge sys_clk);
        q <= '0;
        if (m[8'hA6][1:0] == 2'h0 || a == 8'hA6) m[a] = d & k[a];
        @(negedge sys_clk);
    endtask : wr
    task automatic rd(logic [7:0] a);
        q <= '{a, 1'b0, 1'b1, 8'h00};
        @(negedge sys_clk);
        q <= '0;
        chk("rdata", (m[8'hA6][1:0] == 2'h0 || a == 8'hA6) ? m[a] : 8'h00, rdv);
        @(negedge sys_clk);
    endtask : rd
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // Cuts a hang short.
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
    // Scenario sequence.
    initial begin
        int j;
        void'($urandom(61200));
        foreach (OFS[i]) k[OFS[i]] = MSK[i];
        m[8'h02] = 8'h08;
        m[8'h0A] = 8'h03;
        m[8'h0F] = 8'h03;
        repeat (10) @(negedge sys_clk);
        rst <= 1'b0;
        foreach (OFS[i]) rd(OFS[i]);
        rd(8'h01);
        repeat (40) begin
            j = $urandom_range(16, 1);
            wr(OFS[j], 8'($urandom));
            rd(OFS[j]);
        end
        chk("ram_map", {m[8'h05][7:4], m[8'h05][2:0]}, rm);
        chk("count", {m[8'h11][6:0], m[8'h10]}, bc);
        wr(8'hA6, 8'hFD);
        wr(8'h3F, 8'h5A);
        rd(8'h3F);
        wr(8'hA6, 8'h00);
        rd(8'h3F);
        wr(8'h04, 8'h00);
        @(negedge sys_clk);
        chk("a15", 1'b1, a15o);
        wr(8'h04, 8'h01);
        @(negedge sys_clk);
        repeat (6) begin
            a15 <= 1'($urandom);
            @(negedge sys_clk);
            chk("a15", a15, a15o);
        end
        wr(8'h04, 8'h07);
        for (int b = 0; b < 3; b++) begin
            ev[b] <= 1'b1;
            @(negedge sys_clk);
            ev[b] <= 1'b0;
            m[8'h04][7 - b] = 1'b1;
            rd(8'h04);
            wr(8'h04, 8'h07 | (8'h80 >> b));
            rd(8'h04);
        end
        for (int b = 3; b < 8; b++) begin
            wr(8'h00, 8'hC7);
            repeat (2) @(negedge sys_clk);
            tk = 0;
            repeat (20) @(negedge sys_clk);
            chk("stop", 15'h0, 15'(tk));
            ev[b] <= 1'b1;
            @(negedge sys_clk);
            ev[b] <= 1'b0;
            m[8'h00] = 8'hC0;
            rd(8'h00);
            chk("wait", bra ? 2'h0 : 2'h3, ws);
        end
        wr(8'h29, 8'h02);
        wr(8'h00, 8'h03);
        repeat (16) @(negedge sys_clk);
        tk = 0;
        td = 0;
        repeat (64) @(negedge sys_clk);
        chk("div", 15'h8, 15'(tk));
        chk("dma", 15'h10, 15'(td));
        ea <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(8'h02, 8'h88 | 8'(c));
            repeat (2) @(negedge sys_clk);
            chk("ce", 8'(~(8'h01 << c)), cen);
        end
        key <= 1'b1;
        repeat (5) @(negedge sys_clk);
        key <= 1'b0;
        repeat (3) @(negedge sys_clk);
        m[8'hA6][7] = 1'b1;
        rd(8'hA6);
        wr(8'hA6, 8'h80);
        rd(8'hA6);
        key <= 1'b1;
        wr(8'hA6, 8'h80);
        repeat (30) @(negedge sys_clk);
        m[8'hA6][6] = 1'b1;
        rd(8'hA6);
        final_report();
    end
endmodule : scbr_regs_tb_top
